/* verilog/ssm_stop_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "ssm_defines.vh"

module ssm_stop_ctrl (
  input wire core_clk,
  input wire sys_rst,
  // Pin-level inputs, asynchronous to core_clk
  input wire drive_enable_in,
  input wire fwd_limit_input,
  input wire rev_limit_input,
  input wire estop_input,
  // Active level for each limit and stop pin: 1 means high is valid
  input wire fwd_limit_active_high,
  input wire rev_limit_active_high,
  input wire estop_active_high,
  // Settings, same clock domain
  input wire enable_off_stop_mode,
  input wire class2_fault_stop_mode,
  input wire [1:0] overtravel_stop_mode,
  input wire soft_emergency_stop,
  input wire holding_brake_en,
  // Fault class levels from the fault logic, same clock domain
  input wire class1_fault,
  input wire class2_fault,
  // Speed feedback, same clock domain
  input wire speed_is_zero,
  // Outputs
  output reg [2:0] torque_cmd,
  output reg running,
  output reg fwd_inhibit,
  output reg rev_inhibit,
  output reg overtravel_active,
  output reg emergency_stop_warning,
  output reg stop_done
);

  ////////////////////////////////////////////////////////////////////////////
  // State codes, one-hot
  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_COAST = 5'h02;
  localparam [4:0] ST_DECEL = 5'h04;
  localparam [4:0] ST_HOLD_FREE = 5'h08;
  localparam [4:0] ST_HOLD_LOCK = 5'h10;

  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg zero_reg;
  reg zero_next;
  reg lock_reg;
  reg lock_next;
  wire en_pin;
  wire fwd_valid;
  wire rev_valid;
  wire estop_valid;
  reg stop_req;
  reg stop_zero;
  reg stop_lock;
  wire any_ot;
  wire cause_class1;
  wire cause_class2;
  wire cause_enable_off;
  wire cause_estop;
  wire cause_ot;

  ////////////////////////////////////////////////////////////////////////////
  // Pin level against its configured active logic
  function pin_valid;
    input level;
    input active_high;
    begin
      pin_valid = ~(level ^ active_high);
    end
  endfunction

  // One-bit stop code: 1 asks for a zero-speed stop
  function mode_is_zero;
    input mode;
    begin
      mode_is_zero = (mode == 1'b1);
    end
  endfunction

  // Hold state chosen by the lock flag
  function [4:0] hold_state;
    input lock;
    begin
      hold_state = lock ? ST_HOLD_LOCK : ST_HOLD_FREE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the pins
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {estop_input, rev_limit_input, fwd_limit_input,
                    drive_enable_in};
      // Only the second stage feeds logic
      sync2_reg <= sync1_reg;
    end
  end

  // Limit and stop validity judged against each pin's active logic
  assign en_pin = sync2_reg[0];
  assign fwd_valid = pin_valid(sync2_reg[1], fwd_limit_active_high);
  assign rev_valid = pin_valid(sync2_reg[2], rev_limit_active_high);
  assign estop_valid = pin_valid(sync2_reg[3], estop_active_high);
  assign any_ot = fwd_valid | rev_valid;

  // Stop causes, highest priority first
  assign cause_class1 = class1_fault;
  assign cause_class2 = class2_fault;
  assign cause_enable_off = ~en_pin | soft_emergency_stop;
  assign cause_estop = estop_valid;
  assign cause_ot = any_ot;

  ////////////////////////////////////////////////////////////////////////////
  // Stop cause arbitration; most severe cause wins
  always @* begin
    stop_req = 1'b1;
    stop_zero = 1'b0;
    stop_lock = 1'b0;
    if (cause_class1) begin
      // Class 1 always coasts and ends free running
      stop_zero = 1'b0;
      stop_lock = 1'b0;
    end else if (cause_class2) begin
      stop_lock = 1'b0;
      if (holding_brake_en) begin
        stop_zero = 1'b1;
      end else begin
        stop_zero = mode_is_zero(class2_fault_stop_mode);
      end
    end else if (cause_enable_off) begin
      // Soft stop shares the enable-off setting
      stop_zero = mode_is_zero(enable_off_stop_mode);
      stop_lock = 1'b0;
    end else if (cause_estop) begin
      // Emergency input brakes and locks
      stop_zero = 1'b1;
      stop_lock = 1'b1;
    end else if (cause_ot) begin
      // Either limit stops the drive; code 3 acts as code 2
      case (overtravel_stop_mode)
        `SSM_OT_FREE: begin
          stop_zero = 1'b0;
          stop_lock = 1'b0;
        end
        `SSM_OT_ZERO_LOCK: begin
          stop_zero = 1'b1;
          stop_lock = 1'b1;
        end
        default: begin
          stop_zero = 1'b1;
          stop_lock = 1'b0;
        end
      endcase
    end else begin
      stop_req = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop sequencer
  always @* begin
    state_next = state_reg;
    zero_next = zero_reg;
    lock_next = lock_reg;
    case (state_reg)
      ST_RUN: begin
        // Any cause starts a stop
        if (stop_req) begin
          zero_next = stop_zero;
          lock_next = stop_lock;
          state_next = stop_zero ? ST_DECEL : ST_COAST;
        end
      end
      ST_COAST, ST_DECEL: begin
        // A more severe cause may demand a coast, a brake or a new hold
        if (!stop_req) begin
          state_next = ST_RUN;
        end else begin
          zero_next = stop_zero;
          lock_next = stop_lock;
          if (!stop_zero && speed_is_zero) begin
            state_next = ST_HOLD_FREE;
          end else if (!stop_zero) begin
            state_next = ST_COAST;
          end else if (speed_is_zero) begin
            state_next = hold_state(stop_lock);
          end else begin
            state_next = ST_DECEL;
          end
        end
      end
      ST_HOLD_FREE, ST_HOLD_LOCK: begin
        // At rest; a zero-speed demand while moving brakes again
        if (!stop_req) begin
          state_next = ST_RUN;
        end else if (stop_zero && !speed_is_zero) begin
          state_next = ST_DECEL;
        end else begin
          state_next = hold_state(stop_lock);
        end
        zero_next = stop_zero;
        lock_next = stop_lock;
      end
      default: begin
        // Illegal code: fall back to a coast
        state_next = ST_COAST;
      end
    endcase
  end

  // State and latched stop plan
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= ST_COAST;
      zero_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      zero_reg <= zero_next;
      lock_reg <= lock_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Torque stage command from the next state
  always @(posedge core_clk) begin
    if (sys_rst) begin
      torque_cmd <= 3'h0;
    end else begin
      // Power off unless a state asks for it
      torque_cmd <= 3'h0;
      case (state_next)
        ST_RUN: begin
          torque_cmd[`SSM_TQ_POWER_BIT] <= 1'b1;
        end
        ST_DECEL: begin
          torque_cmd[`SSM_TQ_POWER_BIT] <= 1'b1;
          torque_cmd[`SSM_TQ_BRAKE_BIT] <= 1'b1;
        end
        ST_HOLD_LOCK: begin
          torque_cmd[`SSM_TQ_POWER_BIT] <= 1'b1;
          torque_cmd[`SSM_TQ_LOCK_BIT] <= 1'b1;
        end
        default: begin
          torque_cmd <= 3'h0;
        end
      endcase
    end
  end

  // Status flags from the next state
  always @(posedge core_clk) begin
    if (sys_rst) begin
      running <= 1'b0;
      stop_done <= 1'b0;
    end else begin
      running <= (state_next == ST_RUN);
      // Hold flag rises only once speed has reached zero
      stop_done <= (state_next == ST_HOLD_FREE) ||
                   (state_next == ST_HOLD_LOCK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction inhibits and warning; these follow the pins, not the state
  always @(posedge core_clk) begin
    if (sys_rst) begin
      fwd_inhibit <= 1'b0;
      rev_inhibit <= 1'b0;
      overtravel_active <= 1'b0;
      emergency_stop_warning <= 1'b0;
    end else begin
      // Only the tripped direction is blocked; the way out stays free
      fwd_inhibit <= fwd_valid;
      rev_inhibit <= rev_valid;
      overtravel_active <= any_ot;
      emergency_stop_warning <= estop_valid;
    end
  end

endmodule

`default_nettype wire

/* pkg/ssm_defines.vh */
`ifndef SSM_DEFINES_VH
`define SSM_DEFINES_VH

// Enable-off and class 2 fault stop mode codes
`define SSM_MODE_FREE 2'h0
`define SSM_MODE_ZERO_FREE 2'h1
// Overtravel stop mode codes
`define SSM_OT_FREE 2'h0
`define SSM_OT_ZERO_LOCK 2'h1
`define SSM_OT_ZERO_FREE 2'h2
// Factory values
`define SSM_RST_ENABLE_OFF_MODE 1'h0
`define SSM_RST_CLASS2_MODE 1'h0
`define SSM_RST_OT_MODE 2'h1
`define SSM_RST_SOFT_ESTOP 1'h0
// Torque command field positions on the torque_cmd output
`define SSM_TQ_POWER_BIT 0
`define SSM_TQ_BRAKE_BIT 1
`define SSM_TQ_LOCK_BIT 2

`endif

/* tb/ssm_stop_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module ssm_stop_monitor (
  input wire logic core_clk, sys_rst, drive_enable_in, fwd_limit_input,
  input wire logic rev_limit_input, estop_input, fwd_limit_active_high,
  input wire logic rev_limit_active_high, estop_active_high,
  input wire logic enable_off_stop_mode, class2_fault_stop_mode,
  input wire logic [1:0] overtravel_stop_mode,
  input wire logic soft_emergency_stop, holding_brake_en, class1_fault,
  input wire logic class2_fault, speed_is_zero,
  input wire logic [2:0] torque_cmd,
  input wire logic running, fwd_inhibit, rev_inhibit, overtravel_active,
  input wire logic emergency_stop_warning, stop_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Enable off or soft stop held in free mode
  sequence s_free_req;
    ((!drive_enable_in || soft_emergency_stop) && !enable_off_stop_mode
      && !class2_fault)[*4];
  endsequence
  property p_free; s_free_req |-> torque_cmd == 3'h0 && !running;
  endproperty
  a_free: assert property (p_free)
    else $error("free stop still drives");
  property p_c1; $past(class1_fault) |-> torque_cmd == 3'h0; endproperty
  a_c1: assert property (p_c1)
    else $error("class 1 stop drives");
  property p_fwd; fwd_inhibit == ($past(fwd_limit_input, 3)
    == $past(fwd_limit_active_high)); endproperty
  a_fwd: assert property (p_fwd)
    else $error("forward inhibit wrong");
  property p_rev; rev_inhibit == ($past(rev_limit_input, 3)
    == $past(rev_limit_active_high)); endproperty
  a_rev: assert property (p_rev)
    else $error("reverse inhibit wrong");
  property p_warn; emergency_stop_warning == ($past(estop_input, 3)
    == $past(estop_active_high)); endproperty
  a_warn: assert property (p_warn)
    else $error("warning wrong");
  property p_brake; torque_cmd[1] |-> torque_cmd[0] && !torque_cmd[2]
    && !running && !stop_done; endproperty
  a_brake: assert property (p_brake)
    else $error("braking torque state wrong");
  property p_hold; $rose(stop_done) |-> $past(speed_is_zero); endproperty
  a_hold: assert property (p_hold)
    else $error("hold before zero speed");
  property p_lock; stop_done |-> torque_cmd
    == (torque_cmd[2] ? 3'h5 : 3'h0); endproperty
  a_lock: assert property (p_lock)
    else $error("hold torque wrong");
endmodule
bind ssm_stop_ctrl ssm_stop_monitor u_mon (.*);
`default_nettype wire

/* tb/ssm_field_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Limit and stop switches, pin level from request and active logic
module ssm_field_model (
  input wire logic f_hit, r_hit, e_hit, f_ah, r_ah, e_ah,
  output logic f_pin, r_pin, e_pin
);
  // Contacts settle off the clock edge
  assign #3 f_pin = f_hit ~^ f_ah;
  assign #3 r_pin = r_hit ~^ r_ah;
  assign #3 e_pin = e_hit ~^ e_ah;
endmodule
`default_nettype wire

/* tb/servo_stop_mode_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module servo_stop_mode_control_tb;
  logic core_clk = 0, sys_rst = 1, drive_enable_in = 0, fh = 0, rh = 0;
  logic enable_off_stop_mode = 0, class2_fault_stop_mode = 0, eh = 0;
  logic soft_emergency_stop = 0, holding_brake_en = 0, class1_fault = 0;
  logic class2_fault = 0, speed_is_zero = 0, fwd_limit_active_high = 1;
  logic rev_limit_active_high = 1, estop_active_high = 1;
  logic [1:0] overtravel_stop_mode = 2'h1;
  wire logic fwd_limit_input, rev_limit_input, estop_input, running;
  wire logic fwd_inhibit, rev_inhibit, overtravel_active, stop_done;
  wire logic emergency_stop_warning;
  wire logic [2:0] torque_cmd;
  int n_errors = 0, n_checks = 0, cyc = 0, c;
  ssm_stop_ctrl u_ssm_stop_ctrl (.*);
  ssm_field_model u_ssm_field_model (.f_hit(fh), .r_hit(rh), .e_hit(eh),
    .f_ah(fwd_limit_active_high), .r_ah(rev_limit_active_high),
    .e_ah(estop_active_high), .f_pin(fwd_limit_input),
    .r_pin(rev_limit_input), .e_pin(estop_input));
  always #12.5 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) if (++cyc > 3000) begin
    n_errors++;
    stop_test();
  end
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task stop_test;
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reference: zero-speed flag and lock flag per cause
  function automatic logic [1:0] plan(int k);
    case (k)
      0, 1: return {enable_off_stop_mode, 1'b0};
      2: return 2'h0;
      3: return {class2_fault_stop_mode | holding_brake_en, 1'b0};
      6: return 2'h3;
      default: return {overtravel_stop_mode != 2'h0,
        overtravel_stop_mode == 2'h1};
    endcase
  endfunction
  // Four stops per cause, random modes, then back to run
  initial begin
    logic [1:0] p;
    c = $urandom(79);
    repeat (20) @(posedge core_clk);
    sys_rst <= 0;
    drive_enable_in <= 1;
    for (int i = 0; i < 28; i++) begin
      c = i % 7;
      @(posedge core_clk);
      {enable_off_stop_mode, class2_fault_stop_mode, holding_brake_en,
        overtravel_stop_mode} <= 5'($urandom);
      drive_enable_in <= c != 0;
      soft_emergency_stop <= c == 1;
      class1_fault <= c == 2;
      class2_fault <= c == 3;
      fh <= c == 4;
      rh <= c == 5;
      eh <= c == 6;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      p = plan(c);
      chk({stop_done, torque_cmd, running}, {1'b0, p[1] ? 3'h3 : 3'h0,
        1'b0});
      chk({fwd_inhibit, rev_inhibit, overtravel_active,
        emergency_stop_warning, 1'b0}, {c == 4, c == 5, c == 4 || c == 5,
        c == 6, 1'b0});
      @(posedge core_clk);
      speed_is_zero <= 1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk({stop_done, torque_cmd, running}, {1'b1, p[0] ? 3'h5 : 3'h0,
        1'b0});
      @(posedge core_clk);
      {drive_enable_in, soft_emergency_stop, class1_fault} <= 3'h4;
      {class2_fault, fh, rh, eh, speed_is_zero} <= 5'h00;
      {fwd_limit_active_high, rev_limit_active_high,
        estop_active_high} <= 3'($urandom);
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      chk({stop_done, torque_cmd, running}, 5'h03);
    end
    stop_test();
  end
endmodule
`default_nettype wire
